// ==== pkg/vgwrd_pkg.sv ====
// package: constants, register map and state carrier of the graphics write/read datapath
package vgwrd_pkg;
    // i/o port addresses
    localparam logic [15:0] PORT_INDEX = 16'h03ce;
    localparam logic [15:0] PORT_DATA = 16'h03cf;
    // register indices behind the data port
    localparam logic [3:0] IDX_FILL_VALUE = 4'h0;
    localparam logic [3:0] IDX_FILL_ENABLE = 4'h1;
    localparam logic [3:0] IDX_COMPARE_COLOR = 4'h2;
    localparam logic [3:0] IDX_ROTATE_LOGIC_SELECT = 4'h3;
    localparam logic [3:0] IDX_READ_PLANE_SELECT = 4'h4;
    localparam logic [3:0] IDX_GRAPHICS_MODE_CONTROL = 4'h5;
    localparam logic [3:0] IDX_MEMORY_MAP_CONTROL = 4'h6;
    localparam logic [3:0] IDX_COMPARE_PLANE_MASK = 4'h7;
    localparam logic [3:0] IDX_WRITE_BIT_MASK = 4'h8;
    localparam int NUM_REGS = 9;
    // implemented bits per register, reserved bits store and read as zero
    localparam logic [NUM_REGS-1:0][7:0] REG_IMPL_MASK = {
        8'hff, 8'h0f, 8'h0f, 8'h7b, 8'h03, 8'h1f, 8'h0f, 8'h0f, 8'h0f};
    // reset values
    localparam logic [3:0] INDEX_RESET = 4'h0;
    localparam logic [7:0] REG_RESET = 8'h00;
    // rotate / logic select fields
    localparam int ROT_CNT_LSB = 0;
    localparam int LOGIC_SEL_LSB = 3;
    // graphics mode fields
    localparam int MODE_WRITE_LSB = 0;
    localparam int MODE_READ_COMPARE = 3;
    localparam int MODE_ODD_EVEN = 4;
    localparam int MODE_INTERLEAVE = 5;
    localparam int MODE_256 = 6;
    // memory map fields
    localparam int MAP_GRAPHICS = 0;
    localparam int MAP_CHAIN_OE = 1;
    localparam int MAP_WINDOW_LSB = 2;
    // display buffer windows in host space
    localparam logic [19:0] BASE_A0000 = 20'ha0000;
    localparam logic [19:0] BASE_B0000 = 20'hb0000;
    localparam logic [19:0] BASE_B8000 = 20'hb8000;
    localparam logic [19:0] SIZE_128K = 20'h20000;
    localparam logic [19:0] SIZE_64K = 20'h10000;
    localparam logic [19:0] SIZE_32K = 20'h08000;
    // host read sequence stages
    typedef enum logic [1:0] {RD_IDLE, RD_ISSUE, RD_CAPTURE} vgwrd_rd_t;

    // logic operations
    typedef enum logic [1:0] {LOP_PASS, LOP_AND, LOP_OR, LOP_XOR} vgwrd_lop_t;
    // write modes
    typedef enum logic [1:0] {WM_FILL, WM_LATCH, WM_EXPAND, WM_MASKED} vgwrd_wmode_t;

    // whole state of the datapath
    typedef struct packed {
        logic [3:0] index;                    // graphics index
        logic [NUM_REGS-1:0][7:0] regs;       // indexed registers
        logic [3:0][7:0] latch;               // per-plane read latches
        vgwrd_rd_t rd_stage;                  // host read progress
        logic [1:0] rd_plane;                 // plane chosen for plane read
        logic [7:0] io_rdata;                 // i/o read answer
        logic io_rvalid;                      // i/o read answer pulse
        logic [7:0] host_rdata;               // host memory read answer
        logic host_rvalid;                    // host memory read pulse
        logic host_ready;                     // accepting memory requests
        logic [15:0] plane_addr;              // plane memory address
        logic plane_rd;                       // plane memory read strobe
        logic [3:0] plane_we;                 // plane memory write strobes
        logic [3:0][7:0] plane_wdata;         // per-plane write bytes
        logic shift_il;                       // serial interleave level
    } vgwrd_state_t;
endpackage : vgwrd_pkg

// ==== logic/vgwrd_datapath.sv ====
// module: graphics controller datapath between host memory cycles and four display planes
`timescale 1ns/10ps

module vgwrd_datapath (
    input wire logic mclk,                    // 40 MHz clock
    input wire logic rstn,                    // async reset, active low
    input wire logic [15:0] io_addr,          // i/o port address
    input wire logic io_wr,                   // i/o write strobe
    input wire logic io_rd,                   // i/o read strobe
    input wire logic [7:0] io_wdata,          // i/o write data
    output logic [7:0] io_rdata,              // i/o read data
    output logic io_rvalid,                   // i/o read data valid pulse
    input wire logic mem_wr,                  // host memory write request
    input wire logic mem_rd,                  // host memory read request
    input wire logic [19:0] host_addr,        // host memory address
    input wire logic [7:0] host_wdata,        // host memory write data
    input wire logic chain4,                  // four-plane chaining from sequencer
    output logic host_ready,                  // memory requests accepted
    output logic [7:0] host_rdata,            // host memory read data
    output logic host_rvalid,                 // host read data valid pulse
    output logic [15:0] plane_addr,           // plane memory address
    output logic plane_rd,                    // plane memory read strobe
    output logic [3:0] plane_we,              // plane write strobes
    output logic [31:0] plane_wdata,          // plane write bytes, plane n at [8n+7:8n]
    input wire logic [31:0] plane_rdata,      // plane read bytes, cycle after plane_rd
    output logic shift_interleave,            // serial data odd/even interleave
    output logic shift_256,                   // 256-colour shift loading
    output logic odd_even_host,               // odd/even host addressing enabled
    output logic chain_odd_even,              // A0 selects odd/even plane
    output logic graphics_addr_mode           // graphics addressing, font latches off
);

    vgwrd_pkg::vgwrd_state_t st_ff;           // registered state
    vgwrd_pkg::vgwrd_state_t nxt_st;          // next state

    // right-rotate a byte by 0..7 positions
    function automatic logic [7:0] ror8(input logic [7:0] d, input logic [2:0] n);
        logic [15:0] w;
        w = {d, d} >> n;
        return w[7:0];
    endfunction : ror8

    // combine one byte with a latch byte by the selected operation
    function automatic logic [7:0] lop8(input logic [7:0] d, input logic [7:0] l,
                                        input vgwrd_pkg::vgwrd_lop_t op);
        logic [7:0] r;
        r = d;
        case (op)
            vgwrd_pkg::LOP_PASS: r = d;
            vgwrd_pkg::LOP_AND: r = d & l;
            vgwrd_pkg::LOP_OR: r = d | l;
            vgwrd_pkg::LOP_XOR: r = d ^ l;
            default: r = d;
        endcase
        return r;
    endfunction : lop8

    // register fields
    logic [7:0] r_fill;                       // fill values
    logic [7:0] r_fill_en;                    // fill enables
    logic [7:0] r_color;                      // compare colour
    logic [7:0] r_rot;                        // rotate and logic select
    logic [7:0] r_rps;                        // read plane select
    logic [7:0] r_mode;                       // graphics mode control
    logic [7:0] r_map;                        // memory map control
    logic [7:0] r_cmask;                      // compare plane mask
    logic [7:0] r_bmask;                      // write bit mask
    vgwrd_pkg::vgwrd_lop_t lop;               // selected logic operation
    vgwrd_pkg::vgwrd_wmode_t wmode;           // selected write mode
    logic [7:0] rotated;                      // rotated host byte
    logic win_hit;                            // address in display window
    logic [19:0] win_off;                     // offset inside window
    logic [15:0] p_addr;                      // plane address for request
    logic [3:0] oe_planes;                    // planes reachable this cycle
    logic [3:0][7:0] src;                     // per-plane data before logic op
    logic [3:0][7:0] proc;                    // per-plane data after logic op
    logic [3:0][7:0] wbyte;                   // per-plane final write byte
    logic [7:0] wmask;                        // effective write mask
    logic [7:0] cmp_res;                      // colour compare result
    logic [3:0][7:0] rd_bytes;                // plane bytes as returned

    // register fields out of the state
    always_comb begin
        r_fill = st_ff.regs[vgwrd_pkg::IDX_FILL_VALUE];
        r_fill_en = st_ff.regs[vgwrd_pkg::IDX_FILL_ENABLE];
        r_color = st_ff.regs[vgwrd_pkg::IDX_COMPARE_COLOR];
        r_rot = st_ff.regs[vgwrd_pkg::IDX_ROTATE_LOGIC_SELECT];
        r_rps = st_ff.regs[vgwrd_pkg::IDX_READ_PLANE_SELECT];
        r_mode = st_ff.regs[vgwrd_pkg::IDX_GRAPHICS_MODE_CONTROL];
        r_map = st_ff.regs[vgwrd_pkg::IDX_MEMORY_MAP_CONTROL];
        r_cmask = st_ff.regs[vgwrd_pkg::IDX_COMPARE_PLANE_MASK];
        r_bmask = st_ff.regs[vgwrd_pkg::IDX_WRITE_BIT_MASK];
        lop = vgwrd_pkg::vgwrd_lop_t'(r_rot[vgwrd_pkg::LOGIC_SEL_LSB +: 2]);
        wmode = vgwrd_pkg::vgwrd_wmode_t'(r_mode[vgwrd_pkg::MODE_WRITE_LSB +: 2]);
        rd_bytes = plane_rdata;
    end

    // display window decode
    always_comb begin
        win_hit = 1'b0;
        win_off = 20'h00000;
        case (r_map[vgwrd_pkg::MAP_WINDOW_LSB +: 2])
            2'b00: begin
                win_off = host_addr - vgwrd_pkg::BASE_A0000;
                win_hit = (host_addr >= vgwrd_pkg::BASE_A0000) &&
                          (win_off < vgwrd_pkg::SIZE_128K);
            end
            2'b01: begin
                win_off = host_addr - vgwrd_pkg::BASE_A0000;
                win_hit = (host_addr >= vgwrd_pkg::BASE_A0000) &&
                          (win_off < vgwrd_pkg::SIZE_64K);
            end
            2'b10: begin
                win_off = host_addr - vgwrd_pkg::BASE_B0000;
                win_hit = (host_addr >= vgwrd_pkg::BASE_B0000) &&
                          (win_off < vgwrd_pkg::SIZE_32K);
            end
            default: begin
                win_off = host_addr - vgwrd_pkg::BASE_B8000;
                win_hit = (host_addr >= vgwrd_pkg::BASE_B8000) &&
                          (win_off < vgwrd_pkg::SIZE_32K);
            end
        endcase
    end

    // plane address and reachable planes
    always_comb begin
        p_addr = win_off[15:0];
        oe_planes = 4'hf;
        if (r_map[vgwrd_pkg::MAP_CHAIN_OE]) begin
            // A0 replaced by a higher address bit; A0 steers odd or even planes
            p_addr = {win_off[15:1], win_off[16]};
            oe_planes = win_off[0] ? 4'ha : 4'h5;
        end
    end

    // write data path: rotate, source select, logic op, mask, latch merge
    always_comb begin
        rotated = ror8(host_wdata, r_rot[vgwrd_pkg::ROT_CNT_LSB +: 3]);
        wmask = r_bmask;
        if (wmode == vgwrd_pkg::WM_MASKED) begin
            wmask = rotated & r_bmask;
        end
        for (int n = 0; n < 4; n++) begin
            case (wmode)
                vgwrd_pkg::WM_FILL: begin
                    // fill-enabled planes take the fill bit, others the rotated byte
                    src[n] = r_fill_en[n] ? {8{r_fill[n]}} : rotated;
                end
                vgwrd_pkg::WM_EXPAND: src[n] = {8{host_wdata[n]}};
                vgwrd_pkg::WM_MASKED: src[n] = {8{r_fill[n]}};
                default: src[n] = st_ff.latch[n];
            endcase
            // logic op after rotation, in modes 0, 2 and 3 only
            proc[n] = (wmode == vgwrd_pkg::WM_LATCH) ? src[n] :
                      lop8(src[n], st_ff.latch[n], lop);
            // masked-off positions carry the latch contents
            wbyte[n] = (wmode == vgwrd_pkg::WM_LATCH) ? st_ff.latch[n] :
                       ((proc[n] & wmask) | (st_ff.latch[n] & ~wmask));
        end
    end

    // colour compare across the four returned plane bytes
    always_comb begin
        for (int b = 0; b < 8; b++) begin
            cmp_res[b] = 1'b1;
            for (int n = 0; n < 4; n++) begin
                // plane excluded when its mask bit is zero
                if (r_cmask[n] && (rd_bytes[n][b] != r_color[n])) begin
                    cmp_res[b] = 1'b0;
                end
            end
        end
    end

    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.io_rvalid = 1'b0;
        nxt_st.host_rvalid = 1'b0;
        nxt_st.plane_rd = 1'b0;
        nxt_st.plane_we = 4'h0;
        // i/o writes: index port, then indexed register at data port
        if (io_wr && (io_addr == vgwrd_pkg::PORT_INDEX)) begin
            nxt_st.index = io_wdata[3:0];
        end else if (io_wr && (io_addr == vgwrd_pkg::PORT_DATA)) begin
            if (st_ff.index < 4'(vgwrd_pkg::NUM_REGS)) begin
                nxt_st.regs[st_ff.index] = io_wdata &
                    vgwrd_pkg::REG_IMPL_MASK[st_ff.index];
            end
        end
        // interleave only while 256-colour loading is off, kept in a flop
        nxt_st.shift_il =
            ~nxt_st.regs[vgwrd_pkg::IDX_GRAPHICS_MODE_CONTROL][vgwrd_pkg::MODE_256] &
            nxt_st.regs[vgwrd_pkg::IDX_GRAPHICS_MODE_CONTROL][vgwrd_pkg::MODE_INTERLEAVE];
        // i/o reads: unmapped index and other ports answer zero
        if (io_rd) begin
            nxt_st.io_rvalid = 1'b1;
            nxt_st.io_rdata = 8'h00;
            if (io_addr == vgwrd_pkg::PORT_INDEX) begin
                nxt_st.io_rdata = {4'h0, st_ff.index};
            end else if ((io_addr == vgwrd_pkg::PORT_DATA) &&
                         (st_ff.index < 4'(vgwrd_pkg::NUM_REGS))) begin
                nxt_st.io_rdata = st_ff.regs[st_ff.index];
            end
        end
        // host read sequence
        case (st_ff.rd_stage)
            vgwrd_pkg::RD_IDLE: begin
                if (mem_rd && win_hit && st_ff.host_ready) begin
                    nxt_st.rd_stage = vgwrd_pkg::RD_ISSUE;
                    nxt_st.host_ready = 1'b0;
                    nxt_st.plane_rd = 1'b1;
                    nxt_st.plane_addr = p_addr;
                    // plane choice: chain4 takes the address, odd/even the A0 bit
                    if (chain4) begin
                        nxt_st.rd_plane = win_off[1:0];
                    end else if (r_map[vgwrd_pkg::MAP_CHAIN_OE]) begin
                        nxt_st.rd_plane = {r_rps[1], win_off[0]};
                    end else begin
                        nxt_st.rd_plane = r_rps[1:0];
                    end
                end else if (mem_wr && win_hit && st_ff.host_ready) begin
                    nxt_st.plane_we = oe_planes;
                    nxt_st.plane_addr = p_addr;
                    nxt_st.plane_wdata = wbyte;
                end
            end
            vgwrd_pkg::RD_ISSUE: begin
                nxt_st.rd_stage = vgwrd_pkg::RD_CAPTURE;
            end
            vgwrd_pkg::RD_CAPTURE: begin
                nxt_st.rd_stage = vgwrd_pkg::RD_IDLE;
                nxt_st.host_ready = 1'b1;
                nxt_st.host_rvalid = 1'b1;
                nxt_st.latch = rd_bytes;
                if (r_mode[vgwrd_pkg::MODE_READ_COMPARE]) begin
                    nxt_st.host_rdata = cmp_res;
                end else begin
                    nxt_st.host_rdata = rd_bytes[st_ff.rd_plane];
                end
            end
            default: begin
                nxt_st.rd_stage = vgwrd_pkg::RD_IDLE;
                nxt_st.host_ready = 1'b1;
            end
        endcase
    end

    // state register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_ff.index <= vgwrd_pkg::INDEX_RESET;
            st_ff.regs <= {vgwrd_pkg::NUM_REGS{vgwrd_pkg::REG_RESET}};
            st_ff.latch <= 32'h00000000;
            st_ff.rd_stage <= vgwrd_pkg::RD_IDLE;
            st_ff.rd_plane <= 2'h0;
            st_ff.io_rdata <= 8'h00;
            st_ff.io_rvalid <= 1'b0;
            st_ff.host_rdata <= 8'h00;
            st_ff.host_rvalid <= 1'b0;
            st_ff.host_ready <= 1'b1;
            st_ff.plane_addr <= 16'h0000;
            st_ff.plane_rd <= 1'b0;
            st_ff.plane_we <= 4'h0;
            st_ff.plane_wdata <= 32'h00000000;
            st_ff.shift_il <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state flops
    assign io_rdata = st_ff.io_rdata;
    assign io_rvalid = st_ff.io_rvalid;
    assign host_ready = st_ff.host_ready;
    assign host_rdata = st_ff.host_rdata;
    assign host_rvalid = st_ff.host_rvalid;
    assign plane_addr = st_ff.plane_addr;
    assign plane_rd = st_ff.plane_rd;
    assign plane_we = st_ff.plane_we;
    assign plane_wdata = st_ff.plane_wdata;
    // mode controls toward the display and addressing logic
    assign shift_256 = r_mode[vgwrd_pkg::MODE_256];
    assign shift_interleave = st_ff.shift_il;
    assign odd_even_host = r_mode[vgwrd_pkg::MODE_ODD_EVEN];
    assign chain_odd_even = r_map[vgwrd_pkg::MAP_CHAIN_OE];
    assign graphics_addr_mode = r_map[vgwrd_pkg::MAP_GRAPHICS];

endmodule : vgwrd_datapath

// ==== test/vgwrd_asserts.sv ====
// checker of the graphics write/read datapath port timing
`timescale 1ns/10ps
module vgwrd_asserts (
    input wire logic mclk, // clock
    input wire logic rstn, // reset, active low
    input wire logic io_rd, // i/o read strobe
    input wire logic io_rvalid, // i/o answer pulse
    input wire logic [7:0] io_rdata, // i/o answer
    input wire logic mem_wr, // memory write request
    input wire logic host_ready, // request accepted
    input wire logic [7:0] host_rdata, // memory read answer
    input wire logic host_rvalid, // memory answer pulse
    input wire logic plane_rd, // plane read strobe
    input wire logic [3:0] plane_we, // plane write strobes
    input wire logic shift_interleave, // odd/even serial
    input wire logic shift_256 // 256-colour loading
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    io_answer_a: assert property (io_rd |=> io_rvalid)
        else $error("i/o read not answered next cycle");
    io_hold_a: assert property (!io_rvalid |-> $stable(io_rdata))
        else $error("i/o answer changed without a read");
    read_seq_a: assert property (plane_rd |-> !host_ready ##1
        (!host_ready && !plane_rd && !host_rvalid) ##1 (host_rvalid && host_ready))
        else $error("memory read sequence broken");
    rvalid_cause_a: assert property (host_rvalid |-> $past(plane_rd, 2))
        else $error("read answer without plane read");
    rdata_hold_a: assert property (!host_rvalid |-> $stable(host_rdata))
        else $error("read answer changed without pulse");
    read_wins_a: assert property (plane_rd |-> plane_we == 4'h0)
        else $error("plane write during plane read");
    we_cause_a: assert property (|plane_we |-> $past(mem_wr && host_ready))
        else $error("plane write without request");
    we_sets_a: assert property (plane_we inside {4'h0, 4'h5, 4'ha, 4'hf})
        else $error("plane write strobes out of pairs");
    shift_mode_a: assert property (shift_256 |-> !shift_interleave)
        else $error("interleave while 256-colour loading");
endmodule : vgwrd_asserts

bind vgwrd_datapath vgwrd_asserts i_chk (.mclk(mclk), .rstn(rstn), .io_rd(io_rd),
    .io_rvalid(io_rvalid), .io_rdata(io_rdata), .mem_wr(mem_wr), .host_ready(host_ready),
    .host_rdata(host_rdata), .host_rvalid(host_rvalid), .plane_rd(plane_rd),
    .plane_we(plane_we), .shift_interleave(shift_interleave), .shift_256(shift_256));

// ==== test/vgwrd_plane_mem.sv ====
// plane memory model answering one cycle after each read strobe
`timescale 1ns/10ps
module vgwrd_plane_mem (
    input wire logic mclk, // clock
    input wire logic [15:0] plane_addr, // plane address
    input wire logic plane_rd, // read strobe
    input wire logic [3:0] plane_we, // write strobes
    input wire logic [31:0] plane_wdata, // write bytes
    output logic [31:0] plane_rdata // read bytes
);
    logic [31:0] mem [0:255]; // four planes side by side
    // answer late by one cycle, scramble the bus when not answering
    always @(posedge mclk) begin
        if (plane_rd) plane_rdata <= mem[plane_addr[7:0]];
        else plane_rdata <= ~plane_rdata;
        for (int n = 0; n < 4; n++)
            if (plane_we[n]) mem[plane_addr[7:0]][8*n +: 8] <= plane_wdata[8*n +: 8];
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 32'h0;
        plane_rdata = 32'h0;
    end
endmodule : vgwrd_plane_mem

// ==== test/vgwrd_testbench.sv ====
// self-checking testbench of the graphics write/read datapath
`timescale 1ns/10ps
module testbench;
    logic mclk = 1'b0, rstn = 1'b0, io_wr = 1'b0, io_rd = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
    logic [15:0] io_addr = 16'h0, plane_addr;
    logic [7:0] io_wdata = 8'h0, host_wdata = 8'h0, io_rdata, host_rdata;
    logic [19:0] host_addr = 20'h0;
    logic io_rvalid, host_ready, host_rvalid, plane_rd, si, s256, oeh, coe, gam;
    logic [3:0] plane_we;
    logic [31:0] plane_wdata, plane_rdata, lat = 32'h0, sm [0:255];
    logic [7:0] rg [0:8], q_io[$], q_host[$];
    logic [51:0] q_we[$];
    logic c4 = 1'b0; // four-plane chaining level toward the design
    int n_errors = 0, n_checks = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    vgwrd_datapath i_dut (.mclk(mclk), .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .host_addr(host_addr), .host_wdata(host_wdata),
        .chain4(c4), .host_ready(host_ready), .host_rdata(host_rdata),
        .host_rvalid(host_rvalid), .plane_addr(plane_addr), .plane_rd(plane_rd),
        .plane_we(plane_we), .plane_wdata(plane_wdata), .plane_rdata(plane_rdata),
        .shift_interleave(si), .shift_256(s256), .odd_even_host(oeh),
        .chain_odd_even(coe), .graphics_addr_mode(gam));
    vgwrd_plane_mem i_mem (.mclk(mclk), .plane_addr(plane_addr), .plane_rd(plane_rd),
        .plane_we(plane_we), .plane_wdata(plane_wdata), .plane_rdata(plane_rdata));
    task automatic final_report();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : final_report
    task automatic tally(input logic ok, input string what);
        n_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : tally
    task automatic cmp_io(input logic [7:0] got);
        tally(q_io.size() > 0 && q_io.pop_front() === got, "i/o read data");
    endtask : cmp_io
    task automatic cmp_host(input logic [7:0] got);
        tally(q_host.size() > 0 && q_host.pop_front() === got, "memory read data");
    endtask : cmp_host
    task automatic cmp_we(input logic [51:0] got);
        tally(q_we.size() > 0 && q_we.pop_front() === got, "plane write");
    endtask : cmp_we
    // expected plane bytes of a host write
    function automatic logic [31:0] wexp(input logic [7:0] h);
        logic [7:0] r, m, p, l;
        logic [31:0] w;
        r = (h >> rg[3][2:0]) | (h << (4'd8 - rg[3][2:0]));
        m = (rg[5][1:0] == 2'd3) ? (r & rg[8]) : rg[8];
        for (int n = 0; n < 4; n++) begin
            l = lat[8*n +: 8];
            case (rg[5][1:0])
                2'd0: p = rg[1][n] ? {8{rg[0][n]}} : r;
                2'd1: p = l;
                2'd2: p = {8{h[n]}};
                default: p = {8{rg[0][n]}};
            endcase
            if (rg[5][1:0] != 2'd1) begin
                case (rg[3][4:3])
                    2'd1: p = p & l;
                    2'd2: p = p | l;
                    2'd3: p = p ^ l;
                    default: p = p;
                endcase
                p = (p & m) | (l & ~m);
            end
            w[8*n +: 8] = p;
        end
        return w;
    endfunction : wexp
    // expected colour compare byte
    function automatic logic [7:0] cmpx(input logic [31:0] v);
        logic [7:0] r;
        r = 8'hff;
        for (int n = 0; n < 4; n++)
            if (rg[7][n]) r = r & ~(v[8*n +: 8] ^ {8{rg[2][n]}});
        return r;
    endfunction : cmpx
    task automatic io_cyc(input logic rd, input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        io_addr = a;
        io_wdata = d;
        io_wr = !rd;
        io_rd = rd;
        @(negedge mclk);
        io_wr = 1'b0;
        io_rd = 1'b0;
    endtask : io_cyc
    task automatic reg_w(input int i, input logic [7:0] v);
        io_cyc(1'b0, vgwrd_pkg::PORT_INDEX, 8'(i));
        io_cyc(1'b0, vgwrd_pkg::PORT_DATA, v);
        if (i < 9) rg[i] = v & vgwrd_pkg::REG_IMPL_MASK[i];
    endtask : reg_w
    task automatic reg_r(input int i);
        io_cyc(1'b0, vgwrd_pkg::PORT_INDEX, 8'(i));
        q_io.push_back(i < 9 ? rg[i] : 8'h00);
        io_cyc(1'b1, vgwrd_pkg::PORT_DATA, 8'h00);
    endtask : reg_r
    task automatic mem(input logic rd, input logic [19:0] a, input logic [7:0] d,
                       input logic take);
        logic [19:0] off;
        logic [15:0] pa;
        logic [3:0] pw;
        logic [1:0] ps;
        logic [31:0] bm, w;
        off = a - (rg[6][3] ? (rg[6][2] ? 20'hb8000 : 20'hb0000) : 20'ha0000);
        pa = rg[6][1] ? {off[15:1], off[16]} : off[15:0];
        pw = rg[6][1] ? (off[0] ? 4'ha : 4'h5) : 4'hf;
        bm = {{8{pw[3]}}, {8{pw[2]}}, {8{pw[1]}}, {8{pw[0]}}};
        if (take && rd) begin
            lat = sm[pa[7:0]];
            ps = c4 ? off[1:0] : (rg[6][1] ? {rg[4][1], off[0]} : rg[4][1:0]);
            q_host.push_back(rg[5][3] ? cmpx(lat) : lat[8*ps +: 8]);
        end else if (take) begin
            w = wexp(d);
            sm[pa[7:0]] = (sm[pa[7:0]] & ~bm) | (w & bm);
            q_we.push_back({pw, pa, w});
        end
        @(negedge mclk);
        host_addr = a;
        host_wdata = d;
        mem_rd = rd;
        mem_wr = !rd;
        @(negedge mclk);
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        if (rd) repeat (3) @(negedge mclk);
    endtask : mem
    // results are taken off the queues as they appear
    always @(posedge mclk) begin
        cyc++;
        if (rstn && io_rvalid) cmp_io(io_rdata);
        if (rstn && host_rvalid) cmp_host(host_rdata);
        if (rstn && plane_we != 4'h0) cmp_we({plane_we, plane_addr, plane_wdata});
        if (cyc == 20000) begin
            n_errors++;
            $display("unexpected at %0t: run too long", $time);
            final_report();
        end
    end
    initial begin
        logic [7:0] a;
        logic [19:0] ha;
        int idx[6] = '{0, 1, 2, 4, 7, 8};
        void'($urandom(63));
        for (int i = 0; i < 256; i++) sm[i] = 32'h0;
        for (int i = 0; i < 9; i++) rg[i] = 8'h00;
        repeat (3) @(negedge mclk);
        rstn = 1'b1;
        for (int i = 0; i < 10; i++) begin
            reg_r(i);
            reg_w(i, 8'hff);
            reg_r(i);
        end
        q_io.push_back(8'h09);
        io_cyc(1'b1, vgwrd_pkg::PORT_INDEX, 8'h00);
        $display("register test done");
        reg_w(6, 8'h01);
        for (int t = 0; t < 64; t++) begin
            a = 8'($urandom);
            foreach (idx[k]) reg_w(idx[k], 8'($urandom));
            reg_w(3, {3'h0, t[1:0], 3'($urandom)});
            reg_w(5, {4'h0, 1'($urandom), 1'b0, t[3:2]});
            mem(1'b1, 20'ha0000 + {12'h0, a}, 8'h00, 1'b1);
            mem(1'b0, 20'ha0000 + {12'h0, a}, 8'($urandom), 1'b1);
            mem(1'b1, 20'ha0000 + {12'h0, a}, 8'h00, 1'b1);
        end
        $display("write and read mode test done");
        reg_w(6, 8'h0d);
        mem(1'b0, 20'ha0000, 8'h5a, 1'b0);
        mem(1'b0, 20'hb8010, 8'h5a, 1'b1);
        $display("window test done");
        reg_w(6, 8'h03);
        reg_w(5, 8'h10);
        for (int t = 0; t < 8; t++) begin
            ha = 20'ha0000 + {3'h0, 1'($urandom), 8'h00, 8'($urandom)};
            reg_w(4, 8'(t[1:0]));
            c4 = t[2];
            mem(1'b0, ha, 8'($urandom), 1'b1);
            mem(1'b1, ha, 8'h00, 1'b1);
        end
        c4 = 1'b0;
        $display("chain test done");
        reg_w(5, 8'h70);
        reg_w(6, 8'h03);
        tally({s256, si, oeh, coe, gam} === 5'b10111, "mode levels");
        reg_w(5, 8'h20);
        tally({s256, si, oeh} === 3'b010, "interleave level");
        repeat (6) @(negedge mclk);
        tally(q_io.size() + q_host.size() + q_we.size() == 0, "results missing");
        $display("level test done");
        final_report();
    end
endmodule : testbench
